// File: rtl/pump_map.vh
`ifndef PUMP_MAP_VH
`define PUMP_MAP_VH

// =====================================================================
// Register address and layout
`define PUMP_CONTROL_ADDR   16'h100D
`define PUMP_CONTROL_RESET  8'h00

// =====================================================================
// Field positions
`define MODE_HI_BIT         7
`define MODE_LO_BIT         6
`define OSC_SEL_BIT         5
`define REQ_FLAG_BIT        2
`define THRESH_FLAG_BIT     1
`define READY_FLAG_BIT      0

// =====================================================================
// Mode encodings
`define MODE_OFF            2'h0
`define MODE_PERIPH         2'h1
`define MODE_AUTO           2'h2
`define MODE_ON             2'h3

// =====================================================================
// Clock source select encodings (one-hot)
`define CLK_SRC_INTERNAL    3'h1
`define CLK_SRC_CONV_RC     3'h2
`define CLK_SRC_SYS_DIV     3'h4

`endif

// File: rtl/level_sync.v
`timescale 1ns/100ps

// =====================================================================
// Two-flop synchroniser per bit
module level_sync #(
  parameter WIDTH = 2
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rst,
  // Data
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_r;
      reg stable_r;
      // First flop feeds only the second
      always @(posedge clock) begin
        if (rst) begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r   <= async_in[i];
          stable_r <= meta_r;
        end
      end
      assign sync_out[i] = stable_r;
    end
  endgenerate

endmodule

// File: rtl/pump_enable_logic.v
`timescale 1ns/100ps
`include "pump_map.vh"

// =====================================================================
// Mode decode: pump enable and peripheral request
module pump_enable_logic (
  // Mode and conditions
  input  wire [1:0] mode,
  input  wire       supply_above,
  input  wire       periph_on,
  // Decisions
  output reg        pump_enable,
  output reg        pump_request
);

  // Combinational mode decode
  always @* begin
    pump_request = 1'b0;
    pump_enable  = 1'b0;
    case (mode)
      `MODE_ON: begin
        pump_enable = 1'b1;
      end
      `MODE_AUTO: begin
        pump_enable = ~supply_above;
      end
      `MODE_PERIPH: begin
        pump_request = periph_on & ~supply_above;
        pump_enable  = periph_on & ~supply_above;
      end
      default: begin
        pump_enable = 1'b0;
      end
    endcase
  end

endmodule

// File: rtl/charge_pump_control.v
// Operation
// - mode 11 turns pump on always
// - mode 10 enables pump below threshold
// - mode 01 needs peripheral on and low
// - mode resets 00, 00 means off
// - select 1 uses internal pump oscillator
// - select 0: RC idle, divided clock converting
// - bit 1 reads supply above threshold
// - bit 0 reads pump steady-state ready
// - bit 2 reads peripheral pump request
// - mode 7:6, select 5, flags 2:0
`timescale 1ns/100ps
`include "pump_map.vh"

module charge_pump_control #(
  parameter ADDR_W = 16
) (
  // Clock and reset
  input  wire              clock,
  input  wire              rst,
  // Register port
  input  wire [ADDR_W-1:0] addr,
  input  wire [7:0]        wdata,
  input  wire              wr_stb,
  input  wire              rd_stb,
  output reg  [7:0]        rdata,
  // Converter and peripheral state
  input  wire              converter_go_bit,
  input  wire              analog_peripheral_on,
  // Analog side, asynchronous
  input  wire              supply_above_threshold,
  input  wire              pump_settled,
  // Analog controls
  output reg               pump_enable,
  output reg  [2:0]        pump_clk_sel
);

  // ===================================================================
  // Control register fields
  reg [1:0] pump_mode_select_r;
  reg       pump_osc_select_r;
  reg       pump_request_flag_r;
  reg       pump_ready_flag_r;
  reg       above_flag_r;

  wire [1:0] synced;
  wire       above_s;
  wire       settled_s;
  wire       enable_nxt;
  wire       request_nxt;
  wire       hit;
  reg  [2:0] clk_sel_nxt;

  assign hit = (addr == `PUMP_CONTROL_ADDR);

  // ===================================================================
  // Input synchronisation
  // two-flop crossing
  level_sync #(
    .WIDTH (2)
  ) u_sync (
    .clock    (clock),
    .rst      (rst),
    .async_in ({pump_settled, supply_above_threshold}),
    .sync_out (synced)
  );
  assign above_s   = synced[0];
  assign settled_s = synced[1];

  // ===================================================================
  // Mode decode
  pump_enable_logic u_enable (
    .mode         (pump_mode_select_r),
    .supply_above (above_s),
    .periph_on    (analog_peripheral_on),
    .pump_enable  (enable_nxt),
    .pump_request (request_nxt)
  );

  // Clock source choice, one-hot
  always @* begin
    if (pump_osc_select_r)
      clk_sel_nxt = `CLK_SRC_INTERNAL;
    else if (converter_go_bit)
      clk_sel_nxt = `CLK_SRC_SYS_DIV;
    else
      clk_sel_nxt = `CLK_SRC_CONV_RC;
  end

  // ===================================================================
  // Writable fields; status bits ignore writes
  always @(posedge clock) begin
    if (rst) begin
      pump_mode_select_r <= 2'h0;
      pump_osc_select_r  <= 1'b0;
    end else if (wr_stb && hit) begin
      pump_mode_select_r <= wdata[`MODE_HI_BIT:`MODE_LO_BIT];
      pump_osc_select_r  <= wdata[`OSC_SEL_BIT];
    end
  end

  // ===================================================================
  // Status and analog outputs, all registered
  always @(posedge clock) begin
    if (rst) begin
      pump_enable         <= 1'b0;
      pump_clk_sel        <= `CLK_SRC_CONV_RC;
      pump_request_flag_r <= 1'b0;
      pump_ready_flag_r   <= 1'b0;
      above_flag_r        <= 1'b0;
    end else begin
      pump_enable         <= enable_nxt;
      pump_clk_sel        <= clk_sel_nxt;
      pump_request_flag_r <= request_nxt;
      // ready only while enabled and settled
      pump_ready_flag_r   <= pump_enable & settled_s;
      above_flag_r        <= above_s;
    end
  end

  // ===================================================================
  // Read port: data one cycle after strobe, zero otherwise
  always @(posedge clock) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd_stb && hit) begin
      // read layout, bits 4:3 read zero
      rdata <= {pump_mode_select_r, pump_osc_select_r, 2'h0,
                pump_request_flag_r, above_flag_r, pump_ready_flag_r};
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule

// File: dv/pump_model.sv
`timescale 1ns/100ps
// ========
// Analog pump and supply comparator
module pump_model (
  // Control and status
  input  wire clock,
  input  wire vdd_low,
  input  wire pump_enable,
  output wire supply_above_threshold,
  output reg  pump_settled
);
  reg [1:0] age_r = 2'h0;
  assign supply_above_threshold = !vdd_low;
  // Settling restarts whenever the pump drops
  always @(posedge clock) begin
    age_r <= pump_enable ? age_r + {1'b0, age_r != 2'h3} : 2'h0;
    pump_settled <= pump_enable && age_r == 2'h3;
  end
endmodule

// File: dv/pump_props.sv
`timescale 1ns/100ps
// ========
// Port checks
module pump_props #(
  parameter ADDR_W = 16
) (
  // Clock, reset, register port
  input wire              clock,
  input wire              rst,
  input wire [ADDR_W-1:0] addr,
  input wire [7:0]        wdata,
  input wire              wr_stb,
  input wire              rd_stb,
  input wire [7:0]        rdata,
  // Pump side
  input wire              converter_go_bit,
  input wire              analog_peripheral_on,
  input wire              supply_above_threshold,
  input wire              pump_enable,
  input wire [2:0]        pump_clk_sel
);
  reg  [2:0] cfg_r;
  wire [1:0] mode = cfg_r[2:1];
  wire       hit  = addr == 16'h100D;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Shadow of the writable fields
  always @(posedge clock) begin
    if (rst) cfg_r <= 3'h0;
    else if (wr_stb && hit) cfg_r <= wdata[7:5];
  end
  property p_idle; !$past(rd_stb) |-> rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("rdata idle");
  property p_back; rd_stb && hit |=> rdata[7:3] == {$past(cfg_r), 2'h0}; endproperty
  a_back: assert property (p_back) else $error("readback");
  property p_on; (mode == 2'h3) [*2] |-> pump_enable; endproperty
  a_on: assert property (p_on) else $error("mode on");
  property p_off; (mode == 2'h0) [*2] |-> !pump_enable; endproperty
  a_off: assert property (p_off) else $error("mode off");
  property p_auto; (mode == 2'h2 && $stable(supply_above_threshold)) [*5]
    |-> pump_enable != supply_above_threshold; endproperty
  a_auto: assert property (p_auto) else $error("mode auto");
  property p_periph; (mode == 2'h1 && $stable(supply_above_threshold)) [*5]
    |-> pump_enable == ($past(analog_peripheral_on) && !supply_above_threshold);
  endproperty
  a_periph: assert property (p_periph) else $error("mode periph");
  property p_int; cfg_r[0] [*2] |-> pump_clk_sel == 3'h1; endproperty
  a_int: assert property (p_int) else $error("clk int");
  property p_rc; (!cfg_r[0] && !converter_go_bit) [*2] |-> pump_clk_sel == 3'h2; endproperty
  a_rc: assert property (p_rc) else $error("clk rc");
  property p_div; (!cfg_r[0] && converter_go_bit) [*2] |-> pump_clk_sel == 3'h4; endproperty
  a_div: assert property (p_div) else $error("clk div");
endmodule
bind charge_pump_control pump_props #(.ADDR_W(ADDR_W)) props_u (
  .clock                  (clock),
  .rst                    (rst),
  .addr                   (addr),
  .wdata                  (wdata),
  .wr_stb                 (wr_stb),
  .rd_stb                 (rd_stb),
  .rdata                  (rdata),
  .converter_go_bit       (converter_go_bit),
  .analog_peripheral_on   (analog_peripheral_on),
  .supply_above_threshold (supply_above_threshold),
  .pump_enable            (pump_enable),
  .pump_clk_sel           (pump_clk_sel)
);

// File: dv/test_charge_pump_control.sv
`timescale 1ns/100ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin fails++; \
  $display("Error %s exp %h got %h", n, e, s); end end
// ========
// Table-driven bench
module test_charge_pump_control;
  reg        clock = 0, rst = 1, wr_stb = 0, rd_stb = 0, vdd_low = 0;
  reg        converter_go_bit = 0, analog_peripheral_on = 0;
  reg [15:0] addr = 0;
  reg [7:0]  wdata = 0, got;
  wire [7:0] rdata;
  wire [2:0] pump_clk_sel;
  wire       pump_enable, supply_above_threshold, pump_settled;
  int        fails = 0, samples_checked = 0;
  // Rows: write, {low, periph, busy}, enable, clock select, status
  reg [23:0] tab [0:8] = '{24'h000202, 24'hC00AC3, 24'hFF59E1, 24'h805C81, 24'h800282,
    24'h404240, 24'h406A45, 24'h402242, 24'h007400};
  charge_pump_control dut_u (
    .clock                  (clock),
    .rst                    (rst),
    .addr                   (addr),
    .wdata                  (wdata),
    .wr_stb                 (wr_stb),
    .rd_stb                 (rd_stb),
    .rdata                  (rdata),
    .converter_go_bit       (converter_go_bit),
    .analog_peripheral_on   (analog_peripheral_on),
    .supply_above_threshold (supply_above_threshold),
    .pump_settled           (pump_settled),
    .pump_enable            (pump_enable),
    .pump_clk_sel           (pump_clk_sel)
  );
  pump_model model_u (
    .clock                  (clock),
    .vdd_low                (vdd_low),
    .pump_enable            (pump_enable),
    .supply_above_threshold (supply_above_threshold),
    .pump_settled           (pump_settled)
  );
  task wr(input [15:0] a, input [7:0] d);
    @(posedge clock) begin addr <= a; wdata <= d; wr_stb <= 1'b1; end
    @(posedge clock) wr_stb <= 1'b0;
  endtask
  task rd(input [15:0] a, output [7:0] d);
    @(posedge clock) begin addr <= a; rd_stb <= 1'b1; end
    @(posedge clock) rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task give_verdict;
    $display("fails=%0d samples_checked=%0d", fails, samples_checked);
    if (fails == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial forever #50 clock = ~clock;
  // Watchdog well beyond the expected run
  initial begin
    #100000;
    fails++;
    give_verdict;
  end
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    // Comparator needs two sync flops and the flag flop before it shows
    repeat (3) @(posedge clock);
    #1 `CHK("rst_enable", 1'h0, pump_enable)
    `CHK("rst_clk_sel", 3'h2, pump_clk_sel)
    rd(16'h100D, got);
    `CHK("reset", 8'h02, got)
    wr(16'h100C, 8'hFF);
    rd(16'h100C, got);
    `CHK("unmapped", 8'h00, got)
    for (int i = 0; i < 9; i++) begin
      wr(16'h100D, tab[i][23:16]);
      {vdd_low, analog_peripheral_on, converter_go_bit} <= tab[i][14:12];
      repeat (16) @(posedge clock);
      #1 `CHK("enable", tab[i][11], pump_enable)
      `CHK("clk_sel", tab[i][10:8], pump_clk_sel)
      rd(16'h100D, got);
      `CHK("status", tab[i][7:0], got)
    end
    give_verdict;
  end
endmodule
